/* inc/uem_pkg.sv */
package uem_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PTR_W  = 5;

  // register byte offsets
  localparam logic [11:0] STATUS_OFF    = 12'h104;
  localparam logic [11:0] MASK_OFF      = 12'h108;
  localparam logic [11:0] SEVERITY_OFF  = 12'h10C;
  localparam logic [11:0] LOG_STATE_OFF = 12'h130;
  localparam logic [11:0] IRQ_MASK_OFF  = 12'h134;

  // error class bit positions
  localparam int unsigned BIT_TRAINING    = 0;
  localparam int unsigned BIT_DLL_PROTO   = 4;
  localparam int unsigned BIT_SURPRISE_DN = 5;
  localparam int unsigned BIT_POISONED    = 12;
  localparam int unsigned BIT_FC_PROTO    = 13;
  localparam int unsigned BIT_CPL_TIMEOUT = 14;
  localparam int unsigned BIT_CPL_ABORT   = 15;
  localparam int unsigned BIT_UNEXP_CPL   = 16;
  localparam int unsigned BIT_RX_OVERFLOW = 17;
  localparam int unsigned BIT_MALFORMED   = 18;
  localparam int unsigned BIT_ECRC        = 19;
  localparam int unsigned BIT_UNSUP_REQ   = 20;
  localparam int unsigned BIT_ACS_VIOL    = 21;

  // implemented class bits, everything else reserved
  localparam logic [31:0] IMPL_BITS      = 32'h003F_F031;
  localparam logic [31:0] STATUS_RESET   = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
  localparam logic [31:0] SEVERITY_RESET = 32'h0006_2031;
  localparam logic [31:0] IRQ_MASK_RESET = 32'h0000_0000;

  // log state register fields
  localparam int unsigned LS_PTR_LSB  = 0;
  localparam int unsigned LS_HELD_BIT = 8;
  localparam int unsigned LS_PNF_BIT  = 9;
  localparam int unsigned LS_PF_BIT   = 10;

  typedef enum logic {
    MSG_IDLE,
    MSG_SEND
  } msg_state_type;

endpackage : uem_pkg

/* rtl/apb_regif.sv */
`timescale 1ns/1ps
module apb_regif
  import uem_pkg::*;
(
  input  wire logic              pclk,     // bus clock
  input  wire logic              presetn,  // async reset, active low
  input  wire logic              psel,     // slave select
  input  wire logic              penable,  // access phase
  input  wire logic              pwrite,   // write when high
  input  wire logic [ADDR_W-1:0] paddr,    // byte address
  input  wire logic [DATA_W-1:0] pwdata,   // write data
  output logic                   pready,   // always ready
  output logic      [DATA_W-1:0] prdata,   // read data
  output logic                   pslverr,  // unmapped access
  input  wire logic [DATA_W-1:0] rd_data,  // selected register value
  input  wire logic              addr_hit, // address maps a register
  output logic                   wr_stb,   // one-cycle write strobe
  output logic      [DATA_W-1:0] wr_data   // data for the strobe
);

  logic [DATA_W-1:0] prdata_ff;
  wire               setup_ph  = psel & ~penable;
  wire               access_ph = psel & penable;

  // zero wait states: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~addr_hit;
  assign wr_stb  = access_ph & pwrite & addr_hit;
  assign wr_data = pwdata;
  assign prdata  = prdata_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_ff <= (~pwrite & addr_hit) ? rd_data : 32'h0000_0000;
    end
  end

endmodule : apb_regif

/* rtl/err_gate.sv */
`timescale 1ns/1ps
module err_gate
  import uem_pkg::*;
(
  input  wire logic [31:0] err_event, // raw class event pulses
  input  wire logic [31:0] gate_en,   // one where reporting is allowed
  input  wire logic [31:0] severity,  // one means fatal
  input  wire logic        dn_port,   // port faces downstream
  output logic      [31:0] set_vec,   // status bits to set
  output logic      [31:0] report,    // unmasked events
  output logic             fatal_hit, // some unmasked fatal event
  output logic             nf_hit     // some unmasked non-fatal event
);

  function automatic logic [31:0] live_classes(input logic [31:0] ev, input logic dn);
    logic [31:0] keep;
    keep = IMPL_BITS;
    keep[BIT_SURPRISE_DN] = dn;
    return ev & keep;
  endfunction : live_classes

  assign set_vec   = live_classes(err_event, dn_port);
  assign report    = live_classes(err_event & gate_en, dn_port);
  assign fatal_hit = |(report & severity);
  assign nf_hit    = |(report & ~severity);

endmodule : err_gate

/* rtl/uncorrectable_error_mask.sv */
//Function
// - mask bit 0 stops training error logging and messaging
// - mask bit 4 stops data link protocol error logging and messaging
// - mask bit 5 stops surprise down reporting; downstream ports only
// - mask bit 12 stops poisoned packet logging and messaging
// - mask bit 13 stops flow control protocol error logging and messaging
// - mask bit 14 stops completion timeout logging and messaging
// - mask bit 15 stops completer abort logging and messaging
// - mask bit 16 stops unexpected completion logging and messaging
// - mask bit 17 stops receiver overflow logging and messaging
// - mask bit 18 stops malformed packet logging and messaging
// - mask bit 19 stops end-to-end CRC error logging and messaging
// - mask bit 20 stops unsupported request logging and messaging
// - each class has a sticky status bit, cleared by writing one; surprise down sets its bit on downstream ports only
// - severity bit chooses fatal (1) or non-fatal (0) message
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module uncorrectable_error_mask
  import uem_pkg::*;
(
  input  wire logic              pclk,        // core clock, 10 MHz
  input  wire logic              presetn,     // async reset, active low
  input  wire logic              psel,        // apb select
  input  wire logic              penable,     // apb access phase
  input  wire logic              pwrite,      // apb write
  input  wire logic [ADDR_W-1:0] paddr,       // apb byte address
  input  wire logic [DATA_W-1:0] pwdata,      // apb write data
  output logic                   pready,      // apb ready
  output logic      [DATA_W-1:0] prdata,      // apb read data
  output logic                   pslverr,     // apb error, unmapped
  input  wire logic [31:0]       err_event,   // class event pulses
  input  wire logic              dn_port_pin, // strap: downstream port
  input  wire logic              hot_reset,   // non-fundamental reset pulse
  output logic                   log_valid,   // header log capture pulse
  output logic      [PTR_W-1:0]  log_class,   // class being logged
  output logic                   msg_valid,   // error message request
  output logic                   msg_fatal,   // message is fatal
  input  wire logic              msg_ready,   // message accepted
  output logic                   irq          // level interrupt
);

  // register state
  logic [31:0]      status_ff;
  logic [31:0]      nxt_status;
  logic [31:0]      mask_ff;
  logic [31:0]      nxt_mask;
  logic [31:0]      sev_ff;
  logic [31:0]      nxt_sev;
  logic [31:0]      irq_mask_ff;
  logic [31:0]      nxt_irq_mask;

  // header log tracking
  logic [PTR_W-1:0] first_ptr_ff;
  logic [PTR_W-1:0] nxt_first_ptr;
  logic             log_held_ff;
  logic             nxt_log_held;
  logic             log_valid_ff;
  logic             nxt_log_valid;

  // message sequencing
  msg_state_type    msg_state_ff;
  msg_state_type    nxt_msg_state;
  logic             pend_fatal_ff;
  logic             nxt_pend_fatal;
  logic             pend_nf_ff;
  logic             nxt_pend_nf;
  logic             msg_fatal_ff;
  logic             nxt_msg_fatal;

  // strap synchroniser
  logic             dn_meta_ff;
  logic             dn_port_ff;

  // bus side
  logic             wr_stb;
  logic [31:0]      wr_data;
  logic [31:0]      rd_data;
  logic             addr_hit;

  // gating
  logic [31:0]      gate_en;
  logic [31:0]      set_vec;
  logic [31:0]      report;
  logic             fatal_hit;
  logic             nf_hit;

  function automatic logic [PTR_W-1:0] lowest_set(input logic [31:0] vec);
    logic [PTR_W-1:0] idx;
    idx = '0;
    for (int i = 31; i >= 0; i--) begin
      if (vec[i]) begin
        idx = PTR_W'(i);
      end
    end
    return idx;
  endfunction : lowest_set

  apb_regif u_regif (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .pready   (pready),
    .prdata   (prdata),
    .pslverr  (pslverr),
    .rd_data  (rd_data),
    .addr_hit (addr_hit),
    .wr_stb   (wr_stb),
    .wr_data  (wr_data)
  );

  // address decode
  wire sel_status   = (paddr == STATUS_OFF);
  wire sel_mask     = (paddr == MASK_OFF);
  wire sel_sev      = (paddr == SEVERITY_OFF);
  wire sel_logstate = (paddr == LOG_STATE_OFF);
  wire sel_irq_mask = (paddr == IRQ_MASK_OFF);

  assign addr_hit = sel_status | sel_mask | sel_sev | sel_logstate | sel_irq_mask;

  wire [31:0] log_state_word = {21'h00_0000, pend_fatal_ff, pend_nf_ff, log_held_ff,
                                3'h0, first_ptr_ff};

  assign rd_data = sel_status   ? status_ff      :
                   sel_mask     ? mask_ff        :
                   sel_sev      ? sev_ff         :
                   sel_logstate ? log_state_word :
                   sel_irq_mask ? irq_mask_ff    : 32'h0000_0000;

  // per-class gate enables, a set mask bit closes the gate
  always_comb begin
    gate_en = 32'h0000_0000;
    gate_en[BIT_TRAINING]    = ~mask_ff[BIT_TRAINING];
    gate_en[BIT_DLL_PROTO]   = ~mask_ff[BIT_DLL_PROTO];
    gate_en[BIT_SURPRISE_DN] = ~mask_ff[BIT_SURPRISE_DN] & dn_port_ff;
    gate_en[BIT_POISONED]    = ~mask_ff[BIT_POISONED];
    gate_en[BIT_FC_PROTO]    = ~mask_ff[BIT_FC_PROTO];
    gate_en[BIT_CPL_TIMEOUT] = ~mask_ff[BIT_CPL_TIMEOUT];
    gate_en[BIT_CPL_ABORT]   = ~mask_ff[BIT_CPL_ABORT];
    gate_en[BIT_UNEXP_CPL]   = ~mask_ff[BIT_UNEXP_CPL];
    gate_en[BIT_RX_OVERFLOW] = ~mask_ff[BIT_RX_OVERFLOW];
    gate_en[BIT_MALFORMED]   = ~mask_ff[BIT_MALFORMED];
    gate_en[BIT_ECRC]        = ~mask_ff[BIT_ECRC];
    gate_en[BIT_UNSUP_REQ]   = ~mask_ff[BIT_UNSUP_REQ];
    gate_en[BIT_ACS_VIOL]    = ~mask_ff[BIT_ACS_VIOL];
  end

  err_gate u_gate (
    .err_event (err_event),
    .gate_en   (gate_en),
    .severity  (sev_ff),
    .dn_port   (dn_port_ff),
    .set_vec   (set_vec),
    .report    (report),
    .fatal_hit (fatal_hit),
    .nf_hit    (nf_hit)
  );

  wire wr_status   = wr_stb & sel_status;
  wire wr_mask     = wr_stb & sel_mask;
  wire wr_sev      = wr_stb & sel_sev;
  wire wr_irq_mask = wr_stb & sel_irq_mask;

  assign nxt_status = ((status_ff & ~(wr_status ? wr_data : 32'h0000_0000)) | set_vec)
                      & IMPL_BITS;

  assign nxt_mask     = wr_mask     ? (wr_data & IMPL_BITS) : mask_ff;
  assign nxt_sev      = wr_sev      ? (wr_data & IMPL_BITS) : sev_ff;
  assign nxt_irq_mask = wr_irq_mask ? (wr_data & IMPL_BITS) : irq_mask_ff;

  // header log: first unmasked error is held until software clears its status
  wire log_release = log_held_ff & ~status_ff[first_ptr_ff];
  wire log_open    = ~log_held_ff | log_release;
  wire log_take    = log_open & (|report);

  assign nxt_log_valid = log_take;
  assign nxt_first_ptr = log_take ? lowest_set(report) : first_ptr_ff;
  assign nxt_log_held  = log_take ? 1'b1 : (log_release ? 1'b0 : log_held_ff);

  // message sequencing, fatal first; repeats while pending coalesce
  always_comb begin
    nxt_msg_state  = msg_state_ff;
    nxt_msg_fatal  = msg_fatal_ff;
    nxt_pend_fatal = pend_fatal_ff;
    nxt_pend_nf    = pend_nf_ff;
    case (msg_state_ff)
      MSG_IDLE: begin
        if (pend_fatal_ff) begin
          nxt_msg_state  = MSG_SEND;
          nxt_msg_fatal  = 1'b1;
          nxt_pend_fatal = 1'b0;
        end else if (pend_nf_ff) begin
          nxt_msg_state = MSG_SEND;
          nxt_msg_fatal = 1'b0;
          nxt_pend_nf   = 1'b0;
        end
      end
      MSG_SEND: begin
        if (msg_ready) begin
          nxt_msg_state = MSG_IDLE;
        end
      end
      default: begin
        nxt_msg_state = MSG_IDLE;
      end
    endcase
    if (fatal_hit) begin
      nxt_pend_fatal = 1'b1;
    end
    if (nf_hit) begin
      nxt_pend_nf = 1'b1;
    end
  end

  assign log_valid = log_valid_ff;
  assign log_class = first_ptr_ff;
  assign msg_valid = (msg_state_ff == MSG_SEND);
  assign msg_fatal = msg_fatal_ff;
  assign irq       = |(status_ff & ~irq_mask_ff);

  // strap comes from a pin, two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dn_meta_ff <= 1'b0;
      dn_port_ff <= 1'b0;
    end else begin
      dn_meta_ff <= dn_port_pin;
      dn_port_ff <= dn_meta_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= STATUS_RESET;
      mask_ff   <= MASK_RESET;
      sev_ff    <= SEVERITY_RESET;
    end else begin
      status_ff <= nxt_status;
      mask_ff   <= nxt_mask;
      sev_ff    <= nxt_sev;
    end
  end

  // sticky log state survives hot reset, like the status it points at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_ptr_ff <= '0;
      log_held_ff  <= 1'b0;
      log_valid_ff <= 1'b0;
    end else begin
      first_ptr_ff <= nxt_first_ptr;
      log_held_ff  <= nxt_log_held;
      log_valid_ff <= nxt_log_valid;
    end
  end

  // non-sticky state: hot reset drops pending messages and interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_state_ff  <= MSG_IDLE;
      msg_fatal_ff  <= 1'b0;
      pend_fatal_ff <= 1'b0;
      pend_nf_ff    <= 1'b0;
      irq_mask_ff   <= IRQ_MASK_RESET;
    end else if (hot_reset) begin
      msg_state_ff  <= MSG_IDLE;
      msg_fatal_ff  <= 1'b0;
      pend_fatal_ff <= 1'b0;
      pend_nf_ff    <= 1'b0;
      irq_mask_ff   <= IRQ_MASK_RESET;
    end else begin
      msg_state_ff  <= nxt_msg_state;
      msg_fatal_ff  <= nxt_msg_fatal;
      pend_fatal_ff <= nxt_pend_fatal;
      pend_nf_ff    <= nxt_pend_nf;
      irq_mask_ff   <= nxt_irq_mask;
    end
  end

endmodule : uncorrectable_error_mask

/* tb/uem_msg_sink.sv */
`timescale 1ns/1ps
module uem_msg_sink (
  input  wire logic       pclk,      // core clock
  input  wire logic       presetn,   // async reset, active low
  input  wire logic       msg_valid, // message offered
  input  wire logic [3:0] stall,     // cycles to hold off accept
  output logic            msg_ready  // one-cycle accept
);
  logic [3:0] wait_ff;
  // ready only while a message is offered, after the chosen stall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ff   <= '0;
      msg_ready <= 1'b0;
    end else if (msg_valid && !msg_ready && wait_ff == stall) begin
      msg_ready <= 1'b1;
    end else begin
      msg_ready <= 1'b0;
      wait_ff   <= (msg_valid && !msg_ready) ? wait_ff + 4'h1 : 4'h0;
    end
  end
endmodule : uem_msg_sink

/* tb/uncorrectable_error_mask_bench.sv */
`timescale 1ns/1ps
module uncorrectable_error_mask_bench;
  import uem_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dn, hot;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, err_event, r;
  logic log_valid, msg_valid, msg_fatal, msg_ready, irq, e, last_fatal;
  logic [PTR_W-1:0] log_class, last_class;
  logic [3:0] stall;
  int miscompares, n_compared, n_log, n_msg, cyc, b;
  int cls[13] = '{0, 4, 5, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21};

  uncorrectable_error_mask i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .err_event, .dn_port_pin(dn), .hot_reset(hot), .log_valid,
    .log_class, .msg_valid, .msg_fatal, .msg_ready, .irq);
  uem_msg_sink i_sink (.pclk, .presetn, .msg_valid, .stall, .msg_ready);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (log_valid) begin n_log++; last_class = log_class; end
    if (msg_valid && msg_ready) begin n_msg++; last_fatal = msg_fatal; end
    cyc++;
    if (cyc == 8000) begin miscompares++; tally_and_finish(); end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic fire(input int k);
    @(posedge pclk);
    err_event <= 32'h1 << k;
    @(posedge pclk);
    err_event <= 32'h0;
    repeat (12) @(posedge pclk);
  endtask : fire
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    err_event = '0; dn = 1'b1; hot = 1'b0; stall = 4'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, MASK_OFF, 0); chk("mask reset", r, MASK_RESET);
    apb(0, SEVERITY_OFF, 0); chk("severity reset", r, SEVERITY_RESET);
    apb(1, MASK_OFF, 32'hFFFF_FFFF);
    apb(0, MASK_OFF, 0); chk("mask reserved", r, IMPL_BITS);
    // one pass per class: masked, then unmasked
    for (int i = 0; i < 13; i++) begin
      b = cls[i];
      stall <= 4'(i % 4);
      apb(1, MASK_OFF, 32'h1 << b);
      n_log = 0; n_msg = 0;
      fire(b);
      chk("masked log", n_log, 0);
      chk("masked msg", n_msg, 0);
      apb(0, STATUS_OFF, 0); chk("status set", r, 32'h1 << b);
      apb(1, STATUS_OFF, 32'h1 << b);
      apb(1, MASK_OFF, 0);
      fire(b);
      chk("log count", n_log, 1);
      chk("log class", 32'(last_class), b);
      chk("msg count", n_msg, 1);
      chk("msg fatal", last_fatal, SEVERITY_RESET[b]);
      apb(1, STATUS_OFF, 32'h1 << b);
      apb(0, STATUS_OFF, 0); chk("status w1c", r, 0);
    end
    fire(BIT_CPL_TIMEOUT);
    chk("irq set", irq, 1);
    // a write lands at the access edge, so look half a cycle later
    apb(1, IRQ_MASK_OFF, 32'h1 << BIT_CPL_TIMEOUT);
    @(negedge pclk);
    chk("irq masked", irq, 0);
    apb(1, IRQ_MASK_OFF, 0);
    @(negedge pclk);
    chk("irq unmasked", irq, 1);
    apb(1, STATUS_OFF, 32'hFFFF_FFFF);
    @(negedge pclk);
    chk("irq cleared", irq, 0);
    // two classes at once: lowest is logged, fatal message leaves first
    n_log = 0;
    n_msg = 0;
    @(posedge pclk);
    err_event <= (32'h1 << BIT_POISONED) | (32'h1 << BIT_FC_PROTO);
    @(posedge pclk);
    err_event <= 32'h0;
    repeat (20) @(posedge pclk);
    chk("pair log count", n_log, 1);
    chk("pair log class", 32'(last_class), BIT_POISONED);
    chk("pair msg count", n_msg, 2);
    chk("pair last fatal", last_fatal, 0);
    apb(1, STATUS_OFF, 32'hFFFF_FFFF);
    apb(1, SEVERITY_OFF, 32'hFFFF_FFFF);
    apb(0, SEVERITY_OFF, 0);
    chk("severity write", r, IMPL_BITS);
    n_msg = 0;
    fire(BIT_POISONED);
    chk("fatal msg count", n_msg, 1);
    chk("poisoned fatal", last_fatal, 1);
    // hot reset keeps the mask, drops the interrupt mask
    apb(1, MASK_OFF, 32'h1 << BIT_ECRC);
    apb(1, IRQ_MASK_OFF, 32'h1 << BIT_ECRC);
    @(posedge pclk);
    hot <= 1'b1;
    @(posedge pclk);
    hot <= 1'b0;
    apb(0, MASK_OFF, 0);
    chk("mask sticky", r, 32'h1 << BIT_ECRC);
    apb(0, IRQ_MASK_OFF, 0);
    chk("irq mask hot", r, IRQ_MASK_RESET);
    // upstream port: surprise down is ignored entirely
    apb(1, STATUS_OFF, 32'hFFFF_FFFF);
    dn <= 1'b0;
    repeat (3) @(posedge pclk);
    n_log = 0;
    fire(BIT_SURPRISE_DN);
    apb(0, STATUS_OFF, 0);
    chk("upstream status", r, 0);
    chk("upstream log", n_log, 0);
    // second full reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, MASK_OFF, 0);
    chk("mask reset again", r, MASK_RESET);
    apb(0, SEVERITY_OFF, 0);
    chk("severity again", r, SEVERITY_RESET);
    apb(0, 12'h200, 0); chk("unmapped err", e, 1);
    apb(0, 12'h109, 0); chk("unaligned data", r, 0);
    tally_and_finish();
  end
endmodule : uncorrectable_error_mask_bench

/* tb/uncorrectable_error_mask_monitor.sv */
`timescale 1ns/1ps
module uncorrectable_error_mask_monitor
  import uem_pkg::*;
(
  input wire logic              pclk,      // core clock
  input wire logic              presetn,   // async reset, active low
  input wire logic              psel,      // apb select
  input wire logic              penable,   // apb access phase
  input wire logic              pwrite,    // apb write
  input wire logic [ADDR_W-1:0] paddr,     // apb address
  input wire logic              pready,    // apb ready
  input wire logic [DATA_W-1:0] prdata,    // apb read data
  input wire logic              pslverr,   // apb error
  input wire logic [31:0]       err_event, // class events
  input wire logic              hot_reset, // soft reset
  input wire logic              log_valid, // log pulse
  input wire logic [PTR_W-1:0]  log_class, // logged class
  input wire logic              msg_valid, // message request
  input wire logic              msg_fatal, // message severity
  input wire logic              msg_ready, // message accept
  input wire logic              irq        // interrupt
);
  logic [31:0] ev_ff;
  wire logic   acc    = psel && penable;
  wire logic   mapped = paddr inside {STATUS_OFF, MASK_OFF, SEVERITY_OFF, LOG_STATE_OFF,
                                      IRQ_MASK_OFF};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ev_ff <= '0;
    else ev_ff <= err_event;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_zero_wait: assert property (acc |-> pready)
    else $error("pready low in access phase");
  chk_unmapped_error: assert property (acc && !mapped |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  chk_mapped_no_error: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access flagged");
  chk_write_data_zero: assert property (acc && pwrite |-> prdata == '0)
    else $error("read data during write");
  chk_log_single_pulse: assert property (log_valid |=> !log_valid)
    else $error("log pulse longer than one cycle");
  chk_log_class_cause: assert property (log_valid |-> ev_ff[log_class])
    else $error("logged class had no event");
  chk_msg_held_stable: assert property (msg_valid && !msg_ready && !hot_reset
                                        |=> msg_valid && $stable(msg_fatal))
    else $error("message dropped before accept");
  chk_irq_rise_cause: assert property ($rose(irq) |-> $past(err_event != '0)
                                       || $past(acc && pwrite) || $past(hot_reset))
    else $error("interrupt rose without cause");
endmodule : uncorrectable_error_mask_monitor

bind uncorrectable_error_mask uncorrectable_error_mask_monitor i_mon (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr, .err_event,
  .hot_reset, .log_valid, .log_class, .msg_valid, .msg_fatal, .msg_ready, .irq
);
